// ==== logic/mhsl_defines.svh ====
// Timing constants for the modem handshake and status indicator block
`ifndef MHSL_DEFINES_SVH
`define MHSL_DEFINES_SVH

// ==========================================================
// Clock
`define MHSL_CLK_HZ        40000000
`define MHSL_MS_DIV        40000

// ==========================================================
// Blink intervals in milliseconds
`define MHSL_ACT_HALF_MS   50
`define MHSL_SEARCH_MS     600
`define MHSL_CTX_FLASH_MS  75
`define MHSL_CTX_GAP_MS    3000
`define MHSL_XFER_FLASH_MS 500

// ==========================================================
// Reset values of the active-low outputs
`define MHSL_OFF_N         1'b1

`endif

// ==== logic/mhsl_pkg.sv ====
// Types for the modem handshake and status indicator block
package mhsl_pkg;

   typedef enum logic [2:0] {
      NS_OFF,
      NS_SEARCH,
      NS_CONTEXT,
      NS_TRANSFER,
      NS_CALL
   } mhsl_net_mode_t;

   typedef enum logic [1:0] {
      LK_IDLE,
      LK_CONNECTED,
      LK_DISCONNECT
   } mhsl_link_state_t;

endpackage : mhsl_pkg

// ==== logic/mhsl_ms_tick.sv ====
// Millisecond enable pulse divider
`timescale 1ns/10ps
`include "mhsl_defines.svh"

module mhsl_ms_tick #(
   parameter int DIV = `MHSL_MS_DIV
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Enable
   output logic      ms_tick
);

   logic [15:0] count;
   logic [15:0] next_count;
   logic        next_tick;

   always_comb begin
      next_tick  = 1'b0;
      next_count = count + 16'h0001;
      if (count == 16'(DIV - 1)) begin
         next_count = 16'h0000;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count   <= 16'h0000;
         ms_tick <= 1'b0;
      end else begin
         count   <= next_count;
         ms_tick <= next_tick;
      end
   end

endmodule : mhsl_ms_tick

// ==== logic/mhsl_top.sv ====
// Modem handshake lines, general-purpose pins and status indicators
//
// Contract
// R1 - CTS low only when ready for data
// R2 - Host sends nothing while CTS high
// R3 - DCD low only while connection can pass data
// R4 - Low DTR permits and holds connection
// R5 - DTR release disconnects per action settings
// R6 - Each GPIO individually input or output
// R7 - Full-duplex indicator low in full duplex
// R8 - Activity indicator 50 ms high/low toggling
// R9 - Link indicator low while link good
// R10 - Network indicator off when off/sleep/alarm
// R11 - Network indicator 600 ms on/off searching
// R12 - Contexts: 75 on, 75 off, 75 on, 3 s off
// R13 - Transfer: 0.5 s flash within 1 s
// R14 - Network indicator steady on during calls
// R15 - Counter-based blinks, fixed state priority
`timescale 1ns/10ps
`include "mhsl_defines.svh"

module mhsl_top #(
   parameter int GPIO_W = 4,
   parameter int MS_DIV = `MHSL_MS_DIV
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // Host handshake pins
   output logic                   cts_n,
   output logic                   dcd_n,
   input  wire logic              dtr_n,
   // Modem core status
   input  wire logic              tx_ready,
   input  wire logic              carrier_up,
   input  wire logic              connect_req,
   output logic                   connected,
   output logic                   hangup,
   output logic                   to_command_mode,
   // Command settings
   input  wire logic [1:0]        dtr_action_setting,
   input  wire logic [2:0]        async_mode_setting,
   // General-purpose pins
   input  wire logic [GPIO_W-1:0] gpio_dir_cfg,
   input  wire logic [GPIO_W-1:0] gpio_out_cfg,
   input  wire logic [GPIO_W-1:0] gpio_in,
   output logic      [GPIO_W-1:0] gpio_out,
   output logic      [GPIO_W-1:0] gpio_oe,
   output logic      [GPIO_W-1:0] gpio_value,
   // Link status for indicators
   input  wire logic              full_duplex,
   input  wire logic              activity,
   input  wire logic              link_good,
   input  wire logic              normal_op,
   // Network status inputs
   input  wire logic              sub_off,
   input  wire logic              sleep_mode,
   input  wire logic              alarm_mode,
   input  wire logic              searching,
   input  wire logic              context_active,
   input  wire logic              packet_exchanged,
   input  wire logic              call_connected,
   // Indicator pins
   output logic                   full_duplex_indicator_n,
   output logic                   activity_indicator_n,
   output logic                   link_good_indicator_n,
   output logic                   network_status_indicator
);

   // ==========================================================
   // Millisecond enable
   // Every blink interval counts whole ticks of this enable
   logic ms_tick;

   mhsl_ms_tick #(
      .DIV     (MS_DIV)
   ) u_tick (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ms_tick (ms_tick)
   );

   function automatic logic [11:0] ms_wrap(input logic [11:0] c, input logic [11:0] per);
      ms_wrap = (c >= per - 12'h001) ? 12'h000 : c + 12'h001;
   endfunction : ms_wrap

   // ==========================================================
   // Connection control
   mhsl_pkg::mhsl_link_state_t lk_state;
   mhsl_pkg::mhsl_link_state_t next_lk_state;
   logic next_connected;
   logic next_hangup;
   logic next_cmd;
   logic next_cts_n;
   logic next_dcd_n;

   always_comb begin
      next_lk_state = lk_state;
      next_hangup   = 1'b0;
      next_cmd      = 1'b0;
      case (lk_state)
         mhsl_pkg::LK_IDLE: begin
            // R4 connect only with DTR asserted
            if (!dtr_n && connect_req && carrier_up) begin
               next_lk_state = mhsl_pkg::LK_CONNECTED;
            end
         end
         mhsl_pkg::LK_CONNECTED: begin
            // R5 DTR release enters disconnect unless action setting is 0
            if (dtr_n && dtr_action_setting != 2'h0) begin
               next_lk_state = mhsl_pkg::LK_DISCONNECT;
            end else if (!carrier_up) begin
               next_lk_state = mhsl_pkg::LK_IDLE;
            end
         end
         mhsl_pkg::LK_DISCONNECT: begin
            // R5 action setting and async mode setting pick the response
            next_lk_state = mhsl_pkg::LK_IDLE;
            if (dtr_action_setting == 2'h1 || async_mode_setting != 3'h0) begin
               next_cmd = 1'b1;
            end else begin
               next_hangup = 1'b1;
            end
         end
         default: next_lk_state = mhsl_pkg::LK_IDLE;
      endcase
      next_connected = (next_lk_state == mhsl_pkg::LK_CONNECTED);
      // R3 DCD low only while data can flow
      next_dcd_n = !(next_connected && carrier_up);
      // R1 CTS low only when ready for host data
      next_cts_n = !tx_ready;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lk_state        <= mhsl_pkg::LK_IDLE;
         connected       <= 1'b0;
         hangup          <= 1'b0;
         to_command_mode <= 1'b0;
         cts_n           <= `MHSL_OFF_N;
         dcd_n           <= `MHSL_OFF_N;
      end else begin
         lk_state        <= next_lk_state;
         connected       <= next_connected;
         hangup          <= next_hangup;
         to_command_mode <= next_cmd;
         cts_n           <= next_cts_n;
         dcd_n           <= next_dcd_n;
      end
   end

   // ==========================================================
   // General-purpose pins
   logic [GPIO_W-1:0] next_gpio_value;

   always_comb begin
      // R6 per-pin direction select
      next_gpio_value = (gpio_dir_cfg & gpio_out_cfg) | (~gpio_dir_cfg & gpio_in);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gpio_out   <= '0;
         gpio_oe    <= '0;
         gpio_value <= '0;
      end else begin
         gpio_out   <= gpio_out_cfg;
         gpio_oe    <= gpio_dir_cfg;
         gpio_value <= next_gpio_value;
      end
   end

   // ==========================================================
   // Link indicators
   logic [11:0] act_cnt;
   logic [11:0] next_act_cnt;
   logic        act_phase;
   logic        next_act_phase;
   logic        next_fdx_n;
   logic        next_act_n;
   logic        next_link_n;

   always_comb begin
      next_act_cnt   = act_cnt;
      next_act_phase = act_phase;
      // R8 50 ms square wave while active
      if (!activity) begin
         next_act_cnt   = 12'h000;
         next_act_phase = 1'b0;
      end else if (ms_tick) begin
         next_act_cnt = ms_wrap(act_cnt, 12'(`MHSL_ACT_HALF_MS));
         if (act_cnt == 12'(`MHSL_ACT_HALF_MS - 1)) begin
            next_act_phase = !act_phase;
         end
      end
      next_act_n  = !(normal_op && activity && !act_phase);
      // R7 full-duplex lamp
      next_fdx_n  = !(normal_op && full_duplex);
      // R9 good link lamp
      next_link_n = !(normal_op && link_good);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         act_cnt                 <= 12'h000;
         act_phase               <= 1'b0;
         full_duplex_indicator_n <= `MHSL_OFF_N;
         activity_indicator_n    <= `MHSL_OFF_N;
         link_good_indicator_n   <= `MHSL_OFF_N;
      end else begin
         act_cnt                 <= next_act_cnt;
         act_phase               <= next_act_phase;
         full_duplex_indicator_n <= next_fdx_n;
         activity_indicator_n    <= next_act_n;
         link_good_indicator_n   <= next_link_n;
      end
   end

   // ==========================================================
   // Network status indicator
   mhsl_pkg::mhsl_net_mode_t ns_mode;
   mhsl_pkg::mhsl_net_mode_t next_ns_mode;
   logic [11:0] ns_cnt;
   logic [11:0] next_ns_cnt;
   logic [11:0] xfer_cnt;
   logic [11:0] next_xfer_cnt;
   logic        next_ns_led;
   logic [11:0] ctx_period;

   // Full context cycle: flash, gap, flash, then the long gap
   assign ctx_period = 12'(3 * `MHSL_CTX_FLASH_MS + `MHSL_CTX_GAP_MS);

   always_comb begin
      // R15 fixed priority of states
      if (sub_off || sleep_mode || alarm_mode) begin
         next_ns_mode = mhsl_pkg::NS_OFF;
      end else if (call_connected) begin
         next_ns_mode = mhsl_pkg::NS_CALL;
      end else if (xfer_cnt != 12'h000) begin
         next_ns_mode = mhsl_pkg::NS_TRANSFER;
      end else if (context_active) begin
         next_ns_mode = mhsl_pkg::NS_CONTEXT;
      end else if (searching) begin
         next_ns_mode = mhsl_pkg::NS_SEARCH;
      end else begin
         next_ns_mode = mhsl_pkg::NS_OFF;
      end

      // R13 flash count loads next cycle, indicator lights two cycles after that, lasts 0.5 s
      // A new packet cannot retrigger a running flash
      next_xfer_cnt = xfer_cnt;
      if (packet_exchanged && xfer_cnt == 12'h000) begin
         next_xfer_cnt = 12'(`MHSL_XFER_FLASH_MS);
      end else if (ms_tick && xfer_cnt != 12'h000) begin
         next_xfer_cnt = xfer_cnt - 12'h001;
      end

      // R15 one phase counter for the search and context blinks
      next_ns_cnt = ns_cnt;
      if (next_ns_mode != ns_mode) begin
         next_ns_cnt = 12'h000;
      end else if (ms_tick) begin
         if (ns_mode == mhsl_pkg::NS_SEARCH) begin
            next_ns_cnt = ms_wrap(ns_cnt, 12'(2 * `MHSL_SEARCH_MS));
         end else begin
            next_ns_cnt = ms_wrap(ns_cnt, ctx_period);
         end
      end

      case (ns_mode)
         // R10 steady off
         mhsl_pkg::NS_OFF:      next_ns_led = 1'b0;
         // R11 600 ms on, 600 ms off
         mhsl_pkg::NS_SEARCH:   next_ns_led = (ns_cnt < 12'(`MHSL_SEARCH_MS));
         // R12 double flash then long gap
         mhsl_pkg::NS_CONTEXT:
            next_ns_led = (ns_cnt < 12'(`MHSL_CTX_FLASH_MS))
                       || (ns_cnt >= 12'(2 * `MHSL_CTX_FLASH_MS)
                           && ns_cnt < 12'(3 * `MHSL_CTX_FLASH_MS));
         // R13 lit for the flash duration
         mhsl_pkg::NS_TRANSFER: next_ns_led = 1'b1;
         // R14 steady on during a call
         mhsl_pkg::NS_CALL:     next_ns_led = 1'b1;
         default:               next_ns_led = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ns_mode                  <= mhsl_pkg::NS_OFF;
         ns_cnt                   <= 12'h000;
         xfer_cnt                 <= 12'h000;
         network_status_indicator <= 1'b0;
      end else begin
         ns_mode                  <= next_ns_mode;
         ns_cnt                   <= next_ns_cnt;
         xfer_cnt                 <= next_xfer_cnt;
         network_status_indicator <= next_ns_led;
      end
   end

endmodule : mhsl_top

// ==== test/mhsl_top_assertions.sv ====
// Concurrent checks on the ports of the handshake and indicator block
`timescale 1ns/10ps
module mhsl_checker #(
   parameter int GPIO_W = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Handshake
   input wire logic cts_n,
   input wire logic dcd_n,
   input wire logic dtr_n,
   input wire logic tx_ready,
   input wire logic carrier_up,
   input wire logic connected,
   input wire logic hangup,
   input wire logic to_command_mode,
   input wire logic [1:0] dtr_action_setting,
   input wire logic [2:0] async_mode_setting,
   // General-purpose pins
   input wire logic [GPIO_W-1:0] gpio_dir_cfg,
   input wire logic [GPIO_W-1:0] gpio_out_cfg,
   input wire logic [GPIO_W-1:0] gpio_in,
   input wire logic [GPIO_W-1:0] gpio_out,
   input wire logic [GPIO_W-1:0] gpio_oe,
   input wire logic [GPIO_W-1:0] gpio_value,
   // Indicators
   input wire logic full_duplex,
   input wire logic link_good,
   input wire logic normal_op,
   input wire logic sub_off,
   input wire logic sleep_mode,
   input wire logic alarm_mode,
   input wire logic call_connected,
   input wire logic full_duplex_indicator_n,
   input wire logic link_good_indicator_n,
   input wire logic network_status_indicator
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic off_any;
   assign off_any = sub_off || sleep_mode || alarm_mode;
   // ====
   // Handshake
   // cts lag
   a_cts_ready: assert property (!$past(rst) |-> cts_n == !$past(tx_ready))
      else $error("cts_n does not follow tx_ready");
   a_dcd_conn: assert property (!$past(rst) |-> dcd_n == !(connected && $past(carrier_up)))
      else $error("dcd_n disagrees with connection state");
   a_dtr_hangup: assert property (connected && dtr_n && dtr_action_setting[1] &&
      async_mode_setting == 3'h0 |=> !connected ##1 hangup && !to_command_mode)
      else $error("hang-up not chosen on dtr release");
   a_dtr_command: assert property (connected && dtr_n && dtr_action_setting != 2'h0 &&
      (!dtr_action_setting[1] || async_mode_setting != 3'h0)
      |=> !connected ##1 to_command_mode && !hangup)
      else $error("command mode not chosen on dtr release");
   // ====
   // Pins and indicators
   // pin direction
   a_gpio_cfg: assert property (!$past(rst) |-> gpio_oe == $past(gpio_dir_cfg) &&
      gpio_out == $past(gpio_out_cfg) &&
      gpio_value == ($past(gpio_dir_cfg) & $past(gpio_out_cfg) |
      ~$past(gpio_dir_cfg) & $past(gpio_in)))
      else $error("gpio outputs wrong");
   a_fdx_link: assert property (!$past(rst) |->
      full_duplex_indicator_n == !($past(normal_op) && $past(full_duplex)) &&
      link_good_indicator_n == !($past(normal_op) && $past(link_good)))
      else $error("duplex or link indicator wrong");
   a_net_off: assert property (off_any [*2] |=> !network_status_indicator)
      else $error("network indicator lit while off");
   a_net_call: assert property ((call_connected && !off_any) [*2]
      |=> network_status_indicator)
      else $error("network indicator dark during call");
endmodule : mhsl_checker

bind mhsl_top mhsl_checker #(.GPIO_W(GPIO_W)) chk_i (.*);

// ==== test/mhsl_host_model.sv ====
// Host side of the serial handshake
`timescale 1ns/10ps
module mhsl_host_model (
   // Clock
   input wire logic clk_sys,
   // Bench control
   input wire logic ready_req,
   input wire logic slow,
   input wire logic have_char,
   // Handshake pins
   input wire logic cts_n,
   output logic dtr_n,
   output logic txd_send
);
   logic [1:0] lag;
   initial begin
      dtr_n = 1'b1;
      txd_send = 1'b0;
      lag = 2'h0;
   end
   always @(posedge clk_sys) begin
      if (ready_req == !dtr_n) lag <= 2'h0;
      else if (!slow || lag == 2'h3) dtr_n <= !ready_req;
      else lag <= lag + 2'h1;
   end
   always @(negedge clk_sys) txd_send <= have_char && !cts_n;
endmodule : mhsl_host_model

// ==== test/mhsl_top_test.sv ====
// Self-checking bench for the handshake and indicator block
`timescale 1ns/10ps
module mhsl_top_test;
   logic clk_sys = 1'b0, rst = 1'b1;
   logic tx_ready, carrier_up, connect_req, full_duplex, activity, link_good, normal_op;
   logic sub_off, sleep_mode, alarm_mode, searching, context_active, packet_exchanged;
   logic call_connected, ready_req, slow, have_char, txd_send;
   logic cts_n, dcd_n, dtr_n, connected, hangup, to_command_mode;
   logic full_duplex_indicator_n, activity_indicator_n, link_good_indicator_n;
   logic network_status_indicator;
   logic [1:0] dtr_action_setting;
   logic [2:0] async_mode_setting;
   logic [3:0] gpio_dir_cfg, gpio_out_cfg, gpio_in, gpio_out, gpio_oe, gpio_value;
   int bad_count = 0, checks = 0, cyc = 0, t0, nh, nc;
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;
   mhsl_top #(.MS_DIV(4)) dut (.*);
   mhsl_host_model host (.*);
   // ====
   // Tasks
   task automatic chk(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask : chk
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : step
   task automatic wait_conn(input logic v);
      int n;
      n = 0;
      while (connected !== v && n < 40) begin
         step(1);
         n++;
      end
      chk(connected === v, "connection state");
      if (connected !== v) give_verdict;
   endtask : wait_conn
   // Indicator held at v from ms a to ms b, with margin at both ends for tick phase
   task automatic led_span(input bit act, input logic v, input int a, input int b);
      while (cyc - t0 < a * 4 + 8) step(1);
      while (cyc - t0 < b * 4 - 4) begin
         chk((act ? activity_indicator_n : network_status_indicator) === v, "pattern");
         step(1);
      end
   endtask : led_span
   // ====
   // Sequence
   initial begin
      {tx_ready, carrier_up, connect_req, full_duplex, activity, link_good} = '0;
      {normal_op, sub_off, sleep_mode, alarm_mode, searching, context_active} = '0;
      {packet_exchanged, call_connected, ready_req, slow, have_char} = '0;
      {dtr_action_setting, async_mode_setting} = '0;
      {gpio_dir_cfg, gpio_out_cfg, gpio_in} = '0;
      step(2);
      rst = 1'b0;
      have_char = 1'b1;
      step(2);
      chk(cts_n === 1'b1 && txd_send === 1'b0, "cts idle");
      tx_ready = 1'b1;
      step(2);
      chk(cts_n === 1'b0 && txd_send === 1'b1, "cts ready");
      tx_ready = 1'b0;
      step(1);
      chk(cts_n === 1'b1, "cts drop");
      for (int k = 0; k < 5; k++) begin
         dtr_action_setting = (k < 4) ? k[1:0] : 2'h2;
         async_mode_setting = (k < 4) ? 3'h0 : 3'h5;
         slow = k[0];
         {connect_req, carrier_up, ready_req} = 3'b111;
         wait_conn(1'b1);
         chk(dcd_n === 1'b0, "dcd on");
         {connect_req, ready_req, nh, nc} = '0;
         repeat (12) begin
            step(1);
            nh += hangup;
            nc += to_command_mode;
         end
         chk(nh == (k == 2 || k == 3) && nc == (k == 1 || k == 4), "release");
         chk(connected === (k == 0), "dtr hold");
         carrier_up = 1'b0;
         step(3);
         chk(connected === 1'b0 && dcd_n === 1'b1, "carrier loss");
      end
      for (int k = 0; k < 3; k++) begin
         gpio_dir_cfg = 4'h5 << k;
         gpio_out_cfg = 4'h3 + k[3:0];
         gpio_in = 4'ha ^ k[3:0];
         step(2);
         chk(gpio_oe === gpio_dir_cfg && gpio_out === gpio_out_cfg &&
            gpio_value === (gpio_dir_cfg & gpio_out_cfg | ~gpio_dir_cfg & gpio_in), "gpio");
      end
      {full_duplex, link_good} = 2'b11;
      step(2);
      chk(full_duplex_indicator_n === 1'b1 && link_good_indicator_n === 1'b1, "idle");
      normal_op = 1'b1;
      step(2);
      chk(full_duplex_indicator_n === 1'b0 && link_good_indicator_n === 1'b0, "lit");
      link_good = 1'b0;
      step(2);
      chk(link_good_indicator_n === 1'b1, "link lost");
      activity = 1'b1;
      t0 = cyc;
      led_span(1, 0, 0, 50);
      led_span(1, 1, 50, 100);
      led_span(1, 0, 100, 150);
      activity = 1'b0;
      step(2);
      chk(activity_indicator_n === 1'b1, "act idle");
      searching = 1'b1;
      t0 = cyc;
      led_span(0, 1, 0, 600);
      led_span(0, 0, 600, 1200);
      led_span(0, 1, 1200, 1300);
      context_active = 1'b1;
      t0 = cyc;
      led_span(0, 1, 0, 75);
      led_span(0, 0, 75, 150);
      led_span(0, 1, 150, 225);
      led_span(0, 0, 225, 3225);
      led_span(0, 1, 3225, 3300);
      packet_exchanged = 1'b1;
      t0 = cyc;
      step(1);
      packet_exchanged = 1'b0;
      led_span(0, 1, 0, 500);
      led_span(0, 0, 576, 650);
      call_connected = 1'b1;
      t0 = cyc;
      led_span(0, 1, 0, 700);
      for (int k = 0; k < 3; k++) begin
         {sub_off, sleep_mode, alarm_mode} = 3'b001 << k;
         step(4);
         chk(network_status_indicator === 1'b0, "net off");
      end
      give_verdict;
   end
endmodule : mhsl_top_test
